// *** logic/mcc_monitor_calibration_config.sv ***
/*
  Monitor calibration bank: AXI4-Lite register file, range decode, serial
  address select, start-up bias step limiter and measurement correction.
  Assumes the password logic drives pw2 granted on aclk, and that bias and
  measurement inputs are produced on aclk.
*/
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - During start-up each bias upper-byte change is limited to the step byte.
// - Modulation range byte keeps only bits 2:0; upper bits read zero.
// - Modulation code 000 gives full 1.25 V, down to 25.18 percent at 111.
// - With address select set, serial address is bits 7:1 of address byte.
// - With address select clear, serial address is the fixed A2h.
// - Comparison range bits 2:0 set one full scale for fault and power loop.
// - Comparison code 000 gives full 2.5 V, down to 25.26 percent at 111.
// - Monitor one and two results shift right by bits 6:4 and 2:0.
// - Monitor three result shifts right by bits 6:4 of second shift byte.
// - Supply gain word, high byte first, scales supply measurements.
// - Three monitor gain words scale the three monitor measurements.
// - Supply offset word has sign bits then magnitude weighted 2^15 to 2^2.
// - Each monitor has its own signed offset word in the same format.
// - Bank reads and writes only work while level two access is granted.
// - Bank contents are retained storage, reset only to factory values; here every aresetn reloads SLOT_RST.
module mcc_monitor_calibration_config (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic [mcc_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [mcc_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [mcc_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [mcc_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic                         password_level_two,
  input  wire logic                         startup_active,
  input  wire logic [7:0]                   bias_target_upper,
  output logic [7:0]                        bias_current_output,
  input  wire mcc_pkg::mcc_meas_s           meas_in,
  output mcc_pkg::mcc_meas_s                meas_out,
  output mcc_pkg::mcc_cfg_s                 cfg_out
);
  import mcc_pkg::*;

  // ==========================================================================
  // Storage and bus state
  logic [15:0]        slot_reg  [NUM_SLOTS];
  logic [15:0]        slot_next [NUM_SLOTS];
  logic               aw_full_reg;
  logic               aw_full_next;
  logic               w_full_reg;
  logic               w_full_next;
  logic [ADDR_W-1:0]  awaddr_reg;
  logic [ADDR_W-1:0]  awaddr_next;
  logic [15:0]        wdata_reg;
  logic [15:0]        wdata_next;
  logic [1:0]         wstrb_reg;
  logic [1:0]         wstrb_next;
  logic               awready_reg;
  logic               awready_next;
  logic               wready_reg;
  logic               wready_next;
  logic               bvalid_reg;
  logic               bvalid_next;
  logic [1:0]         bresp_reg;
  logic [1:0]         bresp_next;
  logic               arready_reg;
  logic               arready_next;
  logic               rvalid_reg;
  logic               rvalid_next;
  logic [1:0]         rresp_reg;
  logic [1:0]         rresp_next;
  logic [DATA_W-1:0]  rdata_reg;
  logic [DATA_W-1:0]  rdata_next;

  logic               wr_fire;
  logic               wr_hit;
  logic               wr_rsvd;
  logic [7:0]         wr_idx;
  logic [15:0]        lane_mask;

  logic               rd_hit;
  logic               rd_rsvd;
  logic [7:0]         rd_idx;
  logic [15:0]        rd_val;

  function automatic logic is_reserved(input logic [ADDR_W-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    is_reserved = (a[ADDR_W-1:10] == '0) &&
                  (((i >= IDX_RSVD_A_LO) && (i <= IDX_RSVD_A_HI)) ||
                   ((i >= IDX_RSVD_B_LO) && (i <= IDX_RSVD_B_HI)));
  endfunction

  // ==========================================================================
  // Write channel
  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    wr_idx       = awaddr_reg[9:2];
    wr_hit       = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if ((awaddr_reg[ADDR_W-1:10] == '0) && (wr_idx == SLOT_IDX[i])) begin
        wr_hit = 1'b1;
      end
    end
    wr_rsvd = is_reserved(awaddr_reg);
    // One response outstanding at most
    wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Address and data may arrive in either order
    if (s_axi_awvalid && awready_reg) begin
      aw_full_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata[15:0];
      wstrb_next  = s_axi_wstrb[1:0];
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (password_level_two && (wr_hit || wr_rsvd)) ? RESP_OKAY : RESP_SLVERR;
    end
    awready_next = !aw_full_next;
    wready_next  = !w_full_next;
    lane_mask    = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  end

  generate
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
      assign slot_next[g] =
        (wr_fire && password_level_two && (awaddr_reg[ADDR_W-1:10] == '0) &&
         (wr_idx == SLOT_IDX[g])) ?
        (((slot_reg[g] & ~lane_mask) | (wdata_reg & lane_mask)) & SLOT_MASK[g]) :
        slot_reg[g];
    end
  endgenerate

  // ==========================================================================
  // Read channel
  always_comb begin
    rd_idx = s_axi_araddr[9:2];
    rd_hit = 1'b0;
    rd_val = 16'h0000;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if ((s_axi_araddr[ADDR_W-1:10] == '0) && (rd_idx == SLOT_IDX[i])) begin
        rd_hit = 1'b1;
        rd_val = slot_reg[i];
      end
    end
    rd_rsvd     = is_reserved(s_axi_araddr);
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      if (password_level_two && (rd_hit || rd_rsvd)) begin
        rresp_next = RESP_OKAY;
        rdata_next = {16'h0000, rd_val};
      end else begin
        rresp_next = RESP_SLVERR;
        rdata_next = '0;
      end
    end
    // New address only once the answer is taken
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_reg[i] <= SLOT_RST[i];
      end
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 16'h0000;
      wstrb_reg   <= 2'b00;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= '0;
    end else begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        slot_reg[i] <= slot_next[i];
      end
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // ==========================================================================
  // Configuration view
  mcc_cfg_s           cfg_reg;
  mcc_cfg_s           cfg_next;

  always_comb begin
    cfg_next.startup_step          = slot_reg[SL_STEP][7:0];
    cfg_next.modulation_range_code = slot_reg[SL_MOD][2:0];
    cfg_next.modulation_fs_pct     = MOD_PCT[slot_reg[SL_MOD][2:0]];
    cfg_next.power_loop_range_code = slot_reg[SL_LOOP][2:0];
    cfg_next.power_loop_fs_pct     = LOOP_PCT[slot_reg[SL_LOOP][2:0]];
    // fixed address default
    // Serial address in 8-bit form, bit 0 clear
    if (slot_reg[SL_CFG][ADDRESS_SOURCE_SELECT_BIT]) begin
      cfg_next.serial_address = {slot_reg[SL_ADDR][7:1], 1'b0};
    end else begin
      cfg_next.serial_address = MAIN_ADDR;
    end
    cfg_next.shift_monitor_input_one = slot_reg[SL_SH12][SH_HI_LSB +: 3];
    cfg_next.shift_monitor_input_two = slot_reg[SL_SH12][SH_LO_LSB +: 3];
    cfg_next.shift_monitor_input_three = slot_reg[SL_SH3][SH_HI_LSB +: 3];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= '0;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign cfg_out = cfg_reg;

  // ==========================================================================
  // Start-up bias step limiter
  logic [7:0]         bias_reg;
  logic [7:0]         bias_next;
  logic [7:0]         bias_diff;

  always_comb begin
    // Outside start-up the target passes straight
    bias_next = bias_target_upper;
    bias_diff = 8'h00;
    if (startup_active) begin
      if (bias_target_upper > bias_reg) begin
        bias_diff = bias_target_upper - bias_reg;
        bias_next = (bias_diff > cfg_reg.startup_step) ?
                    8'(bias_reg + cfg_reg.startup_step) : bias_target_upper;
      end else begin
        bias_diff = bias_reg - bias_target_upper;
        bias_next = (bias_diff > cfg_reg.startup_step) ?
                    8'(bias_reg - cfg_reg.startup_step) : bias_target_upper;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_reg <= 8'h00;
    end else begin
      bias_reg <= bias_next;
    end
  end

  assign bias_current_output = bias_reg;

  // ==========================================================================
  // Measurement gain, offset and shift
  mcc_meas_s          meas_reg;
  mcc_meas_s          meas_next;
  logic [31:0]        product;
  logic [15:0]        gain_sel;
  logic [15:0]        offs_sel;
  logic [15:0]        offs_mag;
  logic [16:0]        sum;
  logic [15:0]        corrected;
  logic [2:0]         shift_sel;

  always_comb begin
    gain_sel = slot_reg[SL_GAIN + 4'(meas_in.chan)];
    offs_sel = slot_reg[SL_OFFS + 4'(meas_in.chan)];
    offs_mag = {offs_sel[13:0], 2'b00};
    product  = meas_in.value * gain_sel;
    // Offset saturates at both ends of the range
    if (offs_sel[OFFS_SIGN_BIT]) begin
      sum       = {1'b0, product[31:16]} - {1'b0, offs_mag};
      corrected = sum[16] ? 16'h0000 : sum[15:0];
    end else begin
      sum       = {1'b0, product[31:16]} + {1'b0, offs_mag};
      corrected = sum[16] ? 16'hffff : sum[15:0];
    end
    case (meas_in.chan)
      MCC_CH_MONITOR_INPUT_ONE: shift_sel = cfg_reg.shift_monitor_input_one;
      MCC_CH_MONITOR_INPUT_TWO: shift_sel = cfg_reg.shift_monitor_input_two;
      MCC_CH_MONITOR_INPUT_THREE: shift_sel = cfg_reg.shift_monitor_input_three;
      default:     shift_sel = 3'h0;
    endcase
    meas_next.valid = meas_in.valid;
    meas_next.chan  = meas_in.chan;
    meas_next.value = corrected >> shift_sel;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_reg <= '0;
    end else begin
      meas_reg <= meas_next;
    end
  end

  assign meas_out = meas_reg;

endmodule
`default_nettype wire

// *** logic/mcc_pkg.sv ***
/*
  Constants, register map and carrier types of the monitor calibration bank.
  Assumes a byte-indexed map reached over a 32-bit AXI4-Lite slave port.
*/
`default_nettype none
package mcc_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int          ADDR_W    = 12;
  localparam int          DATA_W    = 32;
  localparam int          NUM_SLOTS = 15;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0]  IDX_CONFIG       = 8'h89;
  localparam logic [7:0]  IDX_STARTUP_STEP = 8'h8a;
  localparam logic [7:0]  IDX_MOD_RANGE    = 8'h8b;
  localparam logic [7:0]  IDX_ALT_ADDR     = 8'h8c;
  localparam logic [7:0]  IDX_LOOP_RANGE   = 8'h8d;
  localparam logic [7:0]  IDX_SHIFT_12     = 8'h8e;
  localparam logic [7:0]  IDX_SHIFT_3      = 8'h8f;
  localparam logic [7:0]  IDX_RSVD_A_LO    = 8'h90;
  localparam logic [7:0]  IDX_RSVD_A_HI    = 8'h91;
  localparam logic [7:0]  IDX_VCC_GAIN     = 8'h92;
  localparam logic [7:0]  IDX_MONITOR_INPUT_ONE_GAIN    = 8'h94;
  localparam logic [7:0]  IDX_MONITOR_INPUT_TWO_GAIN    = 8'h96;
  localparam logic [7:0]  IDX_MONITOR_INPUT_THREE_GAIN    = 8'h98;
  localparam logic [7:0]  IDX_RSVD_B_LO    = 8'h9a;
  localparam logic [7:0]  IDX_RSVD_B_HI    = 8'ha1;
  localparam logic [7:0]  IDX_VCC_OFFS     = 8'ha2;
  localparam logic [7:0]  IDX_MONITOR_INPUT_ONE_OFFS    = 8'ha4;
  localparam logic [7:0]  IDX_MONITOR_INPUT_TWO_OFFS    = 8'ha6;
  localparam logic [7:0]  IDX_MONITOR_INPUT_THREE_OFFS    = 8'ha8;

  // ==========================================================================
  // Storage slots
  localparam logic [3:0]  SL_STEP = 4'h0;
  localparam logic [3:0]  SL_MOD  = 4'h1;
  localparam logic [3:0]  SL_ADDR = 4'h2;
  localparam logic [3:0]  SL_LOOP = 4'h3;
  localparam logic [3:0]  SL_SH12 = 4'h4;
  localparam logic [3:0]  SL_SH3  = 4'h5;
  localparam logic [3:0]  SL_GAIN = 4'h6;
  localparam logic [3:0]  SL_OFFS = 4'ha;
  localparam logic [3:0]  SL_CFG  = 4'he;

  localparam logic [7:0]  SLOT_IDX [NUM_SLOTS] = '{
    IDX_STARTUP_STEP, IDX_MOD_RANGE, IDX_ALT_ADDR, IDX_LOOP_RANGE, IDX_SHIFT_12,
    IDX_SHIFT_3, IDX_VCC_GAIN, IDX_MONITOR_INPUT_ONE_GAIN, IDX_MONITOR_INPUT_TWO_GAIN, IDX_MONITOR_INPUT_THREE_GAIN,
    IDX_VCC_OFFS, IDX_MONITOR_INPUT_ONE_OFFS, IDX_MONITOR_INPUT_TWO_OFFS, IDX_MONITOR_INPUT_THREE_OFFS, IDX_CONFIG};

  // Gain words are calibrated in production; value here is arbitrary
  localparam logic [15:0] GAIN_RESET = 16'h8000;

  localparam logic [15:0] SLOT_RST [NUM_SLOTS] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    GAIN_RESET, GAIN_RESET, GAIN_RESET, GAIN_RESET,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  localparam logic [15:0] SLOT_MASK [NUM_SLOTS] = '{
    16'h00ff, 16'h0007, 16'h00ff, 16'h0007, 16'h0077, 16'h0070,
    16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h0010};

  // ==========================================================================
  // Field positions
  localparam int          ADDRESS_SOURCE_SELECT_BIT      = 4;
  localparam int          SH_HI_LSB     = 4;
  localparam int          SH_LO_LSB     = 0;
  localparam int          OFFS_SIGN_BIT = 15;
  localparam logic [7:0]  MAIN_ADDR     = 8'ha2;

  // ==========================================================================
  // Full-scale fractions in hundredths of a percent
  localparam logic [15:0] MOD_PCT [8] = '{
    16'h2710, 16'h1f45, 16'h1a13, 16'h1395, 16'h0fb0, 16'h0d16, 16'h0b3b, 16'h09d6};
  localparam logic [15:0] LOOP_PCT [8] = '{
    16'h2710, 16'h1f47, 16'h1a17, 16'h139a, 16'h0fb6, 16'h0d1d, 16'h0b42, 16'h09de};

  // ==========================================================================
  // AXI responses and measurement channels
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MCC_CH_VCC  = 2'b00,
    MCC_CH_MONITOR_INPUT_ONE = 2'b01,
    MCC_CH_MONITOR_INPUT_TWO = 2'b10,
    MCC_CH_MONITOR_INPUT_THREE = 2'b11
  } mcc_chan_e;

  typedef struct packed {
    logic             valid;
    mcc_chan_e        chan;
    logic [15:0]      value;
  } mcc_meas_s;

  typedef struct packed {
    logic [7:0]       startup_step;
    logic [2:0]       modulation_range_code;
    logic [15:0]      modulation_fs_pct;
    logic [2:0]       power_loop_range_code;
    logic [15:0]      power_loop_fs_pct;
    logic [7:0]       serial_address;
    logic [2:0]       shift_monitor_input_one;
    logic [2:0]       shift_monitor_input_two;
    logic [2:0]       shift_monitor_input_three;
  } mcc_cfg_s;

endpackage
`default_nettype wire

// *** dv/mcc_monitor_calibration_config_props.sv ***
/*
  Checker of the calibration bank, watching only its top ports.
  Assumes it is bound into the top module by name.
*/
`timescale 1ns/1ns
`default_nettype none
module mcc_monitor_calibration_config_props (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic [mcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [mcc_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       password_level_two,
  input wire logic                       startup_active,
  input wire logic [7:0]                 bias_target_upper,
  input wire logic [7:0]                 bias_current_output,
  input wire mcc_pkg::mcc_cfg_s          cfg_out
);
  import mcc_pkg::*;
  // Full scale in hundredths of a percent
  localparam logic [15:0] MOD_FS [8] = '{16'h2710, 16'h1f45, 16'h1a13, 16'h1395,
                                        16'h0fb0, 16'h0d16, 16'h0b3b, 16'h09d6};
  localparam logic [15:0] LOOP_FS [8] = '{16'h2710, 16'h1f47, 16'h1a17, 16'h139a,
                                         16'h0fb6, 16'h0d1d, 16'h0b42, 16'h09de};
  logic [2:0] up_reg;
  logic [2:0] up_next;
  // ====================
  // Settling after reset
  always_comb up_next = aresetn ? {up_reg[1:0], 1'b1} : 3'h0;
  always_ff @(posedge aclk) up_reg <= up_next;
  function automatic logic [7:0] toward(input logic [7:0] b, t, s);
    if (t > b) return (t - b > s) ? b + s : t;
    return (b - t > s) ? b - s : t;
  endfunction
  // ====================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_reset_dflt:
    assert property ($rose(aresetn) |-> ##[1:3] (cfg_out.serial_address == 8'ha2
      && cfg_out.modulation_range_code == 3'h0)) else $error("bad defaults");
  chk_mod_decode:
    assert property (up_reg[2] |-> cfg_out.modulation_fs_pct
      == MOD_FS[cfg_out.modulation_range_code]) else $error("bad mod scale");
  chk_loop_decode:
    assert property (up_reg[2] |-> cfg_out.power_loop_fs_pct
      == LOOP_FS[cfg_out.power_loop_range_code]) else $error("bad loop scale");
  chk_bias_limit:
    assert property (up_reg[2] && startup_active && $stable(cfg_out.startup_step)
      |=> bias_current_output == toward($past(bias_current_output),
      $past(bias_target_upper), $past(cfg_out.startup_step))) else $error("bad step");
  chk_bias_follow:
    assert property (up_reg[2] && !startup_active |=> bias_current_output
      == $past(bias_target_upper)) else $error("bias not following");
  chk_rd_denied:
    assert property (s_axi_arvalid && s_axi_arready && !password_level_two |=> s_axi_rvalid
      && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("read not refused");
  chk_wr_denied:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1
      !password_level_two |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
      else $error("write not refused");
  chk_rsvd_bits:
    assert property (s_axi_arvalid && s_axi_arready && password_level_two
      && s_axi_araddr == 12'h22c |=> s_axi_rvalid && s_axi_rdata[31:3] == 29'h0
      && s_axi_rresp == RESP_OKAY) else $error("reserved bits set");
endmodule
`default_nettype wire

// *** dv/mcc_host_model.sv ***
/*
  Host model: AXI4-Lite master making single register transfers.
  Assumes its tasks are called just after a rising edge of aclk.
*/
`timescale 1ns/1ns
`default_nettype none
module mcc_host_model (
  input  wire logic                       aclk,
  output var logic [mcc_pkg::ADDR_W-1:0]  s_axi_awaddr,
  output var logic                        s_axi_awvalid,
  input  wire logic                       s_axi_awready,
  output var logic [mcc_pkg::DATA_W-1:0]  s_axi_wdata,
  output var logic [3:0]                  s_axi_wstrb,
  output var logic                        s_axi_wvalid,
  input  wire logic                       s_axi_wready,
  input  wire logic [1:0]                 s_axi_bresp,
  input  wire logic                       s_axi_bvalid,
  output var logic                        s_axi_bready,
  output var logic [mcc_pkg::ADDR_W-1:0]  s_axi_araddr,
  output var logic                        s_axi_arvalid,
  input  wire logic                       s_axi_arready,
  input  wire logic [mcc_pkg::DATA_W-1:0] s_axi_rdata,
  input  wire logic [1:0]                 s_axi_rresp,
  input  wire logic                       s_axi_rvalid,
  output var logic                        s_axi_rready
);
  import mcc_pkg::*;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
  end
  // Released lines show inverted values
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= 12'({idx, 2'b00});
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid) break;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
    end
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= 12'({idx, 2'b00});
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid) break;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~s_axi_araddr;
      end
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
endmodule
`default_nettype wire

// *** dv/mcc_monitor_calibration_config_tb.sv ***
/*
  Self-checking bench of the calibration bank with a reference model.
  Assumes the host model and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module mcc_monitor_calibration_config_tb;
  import mcc_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic              password_level_two = 1'b1;
  logic              startup_active = 1'b0;
  logic [7:0]        bias_target_upper = 8'h00;
  logic [7:0]        bias_current_output;
  mcc_meas_s         meas_in = '0;
  mcc_meas_s         meas_out;
  mcc_cfg_s          cfg_out;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int                n_errors = 0;
  int                total_checks = 0;
  logic [15:0]       m [NUM_SLOTS];
  logic [31:0]       d;
  logic [7:0]        b;
  mcc_monitor_calibration_config u_mcc_monitor_calibration_config (.*);
  mcc_host_model                 u_mcc_host_model (.*);
  always #5 aclk = ~aclk;
  // ====================
  // Model and checks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wm(input logic [3:0] s, input logic [31:0] v);
    u_mcc_host_model.wr(SLOT_IDX[s], v, r);
    chk(r, RESP_OKAY);
    m[s] = v[15:0] & SLOT_MASK[s];
  endtask
  task automatic rc(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
    u_mcc_host_model.rd(i, d, r);
    chk(d, e);
    chk(r, er);
  endtask
  function automatic logic [7:0] step_b(input logic [7:0] x, t, s);
    if (t > x) return (t - x > s) ? x + s : t;
    return (x - t > s) ? x - s : t;
  endfunction
  function automatic logic [15:0] corr(input logic [1:0] c, input logic [15:0] v);
    longint p;
    longint o;
    int sh;
    p = (longint'(v) * m[SL_GAIN + c]) >> 16;
    o = {m[SL_OFFS + c][13:0], 2'b00};
    p = m[SL_OFFS + c][15] ? p - o : p + o;
    p = p < 0 ? 0 : (p > 64'hffff ? 64'hffff : p);
    sh = c == 2'd1 ? m[SL_SH12][6:4] : c == 2'd2 ? m[SL_SH12][2:0] : c == 2'd3 ? m[SL_SH3][6:4] : 0;
    return 16'(p >> sh);
  endfunction
  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ====================
  // Scenarios
  initial begin
    void'($urandom(32'he5e32db6));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    for (int s = 0; s < NUM_SLOTS; s++) m[s] = (s >= 6 && s <= 9) ? GAIN_RESET : 16'h0000;
    for (int s = 0; s < NUM_SLOTS; s++) rc(SLOT_IDX[s], m[s], RESP_OKAY);
    for (int s = 0; s < NUM_SLOTS; s++) begin
      wm(s[3:0], $urandom);
      rc(SLOT_IDX[s], m[s], RESP_OKAY);
    end
    u_mcc_host_model.wr(IDX_RSVD_A_LO, 32'hffff_ffff, r);
    chk(r, RESP_OKAY);
    rc(IDX_RSVD_A_LO, 32'h0, RESP_OKAY);
    rc(IDX_RSVD_B_HI, 32'h0, RESP_OKAY);
    rc(8'h93, 32'h0, RESP_SLVERR);
    password_level_two <= 1'b0;
    u_mcc_host_model.wr(SLOT_IDX[0], ~{16'h0, m[0]}, r);
    chk(r, RESP_SLVERR);
    rc(SLOT_IDX[0], 32'h0, RESP_SLVERR);
    password_level_two <= 1'b1;
    @(posedge aclk);
    rc(SLOT_IDX[0], m[0], RESP_OKAY);
    wm(SL_ADDR, 32'h5b);
    wm(SL_CFG, 32'h10);
    @(posedge aclk);
    chk(cfg_out.serial_address, 8'h5a);
    wm(SL_CFG, 32'h0);
    @(posedge aclk);
    chk(cfg_out.serial_address, 8'ha2);
    for (int c = 0; c < 8; c++) begin
      wm(SL_MOD, c);
      wm(SL_LOOP, 7 - c);
      @(posedge aclk);
      chk({cfg_out.modulation_range_code, cfg_out.power_loop_range_code}, {c[2:0], 3'(7 - c)});
    end
    wm(SL_STEP, 32'h3);
    repeat (2) @(posedge aclk);
    b = 8'h00;
    startup_active <= 1'b1;
    for (int i = 0; i < 64; i++) begin
      @(posedge aclk);
      chk(bias_current_output, b);
      b = startup_active ? step_b(b, bias_target_upper, m[SL_STEP][7:0]) : bias_target_upper;
      if (i % 8 == 0) bias_target_upper <= $urandom;
      if (i == 40) startup_active <= 1'b0;
    end
    for (int i = 0; i < 48; i++) begin
      d = $urandom;
      meas_in <= '{valid: 1'b1, chan: mcc_chan_e'(i[1:0]), value: d[15:0]};
      @(posedge aclk);
      meas_in.valid <= 1'b0;
      @(posedge aclk);
      chk({meas_out.valid, meas_out.chan}, {1'b1, i[1:0]});
      chk(meas_out.value, corr(i[1:0], d[15:0]));
    end
    conclude();
  end
  initial begin
    #100000;
    n_errors++;
    conclude();
  end
endmodule
bind mcc_monitor_calibration_config mcc_monitor_calibration_config_props u_props (.*);
`default_nettype wire
